/* File: src/eeprom_slave.sv */
`timescale 1ns/1ps
// Function
// - write-protect high blocks programming, reads unaffected
// - 128 pages of 32 bytes, 12-bit address
// - sda edge during scl high is condition
// - sample on scl rise, drive after fall
// - start opens command, stop closes it
// - acknowledge low on ninth clock
// - standby after power-up, read stop, programming
// - device code 1010 plus chip-select match
// - unconnected chip-select reads as low
// - address lsb selects read or write
// - byte write: two addresses, data, stop
// - ignore bus during timed write cycle
// - page write up to 32 bytes
// - page write wraps low five bits
// - no acknowledge while programming, polling
// - address counter holds last plus one
// - current read: one byte, no ack, stop
// - controller ack requests next read byte
// - read address wraps at array end
// - repeated start abandons pending write
module eeprom_slave #(
    parameter int WRITE_CYCLES = eeprom_pkg::WRITE_CYCLES
) (
    input wire logic clk, // system clock
    input wire logic rst, // synchronous reset, high
    input wire logic scl_i, // serial clock pin
    input wire logic sda_i, // serial data pin level
    output logic sda_o, // serial data out, always low
    output logic sda_oe, // pull sda low when high
    input wire logic [2:0] chip_select_pins, // strap pins, pulled low
    input wire logic wp_i, // write protect
    output logic busy_q // programming in progress
);
    // ------------------------------------------------------------
    // pin synchronisers and edge detect
    // ------------------------------------------------------------
    logic [1:0] scl_s_q, sda_s_q;
    logic scl_q, sda_q;
    logic scl_rise, scl_fall, start_c, stop_c;
    logic [1:0] wp_s_q;
    logic [2:0] cs_s1_q, cs_s2_q;
    // straps and protect are pins as well, so they pass two flops too
    always_ff @(posedge clk) begin
        if (rst) begin
            scl_s_q <= 2'h3;
            sda_s_q <= 2'h3;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            wp_s_q <= 2'h0;
            cs_s1_q <= 3'h0;
            cs_s2_q <= 3'h0;
        end else begin
            scl_s_q <= {scl_s_q[0], scl_i};
            sda_s_q <= {sda_s_q[0], sda_i};
            scl_q <= scl_s_q[1];
            sda_q <= sda_s_q[1];
            wp_s_q <= {wp_s_q[0], wp_i};
            cs_s1_q <= chip_select_pins;
            cs_s2_q <= cs_s1_q;
        end
    end
    assign scl_rise = scl_s_q[1] & ~scl_q;
    assign scl_fall = ~scl_s_q[1] & scl_q;
    assign start_c = scl_s_q[1] & scl_q & sda_q & ~sda_s_q[1];
    assign stop_c = scl_s_q[1] & scl_q & ~sda_q & sda_s_q[1];

    // ------------------------------------------------------------
    // storage and state
    // ------------------------------------------------------------
    logic [7:0] mem [eeprom_pkg::DEPTH];
    logic [7:0] page_q [32];
    logic [31:0] page_v_q;
    eeprom_pkg::state_t st_q;
    logic [3:0] bit_q;
    logic [7:0] sh_q;
    logic [11:0] addr_q;
    logic [11:0] wbase_q;
    logic [4:0] wptr_q;
    logic rw_q, acking_q, wdata_q, ack_ok;
    logic after_start_q;
    logic [31:0] prog_cnt_q;
    logic [7:0] rd_byte;

    assign rd_byte = mem[addr_q];
    // strap pins are pulled low off chip, so unconnected match zero
    assign ack_ok = (sh_q[7:4] == eeprom_pkg::TYPE_CODE)
                  && (sh_q[3:1] == cs_s2_q);

    // ------------------------------------------------------------
    // start framing
    // ------------------------------------------------------------
    // the scl fall that closes a start is no data clock; counting it
    // would slip every byte by one bit
    always_ff @(posedge clk) begin
        if (rst) begin
            after_start_q <= 1'b0;
        end else if (start_c) begin
            after_start_q <= 1'b1;
        end else if (scl_fall) begin
            after_start_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // bit counter and shifter
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst || start_c) begin
            bit_q <= 4'h0;
        end else if (scl_fall && !after_start_q && st_q != eeprom_pkg::ST_IDLE
                     && st_q != eeprom_pkg::ST_PROG) begin
            bit_q <= (bit_q == eeprom_pkg::ACK_BIT) ? 4'h0 : bit_q + 4'h1;
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            sh_q <= 8'h00;
        end else if (scl_rise && bit_q < eeprom_pkg::ACK_BIT) begin
            sh_q <= {sh_q[6:0], sda_q};
        end
    end

    // ------------------------------------------------------------
    // command sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= eeprom_pkg::ST_IDLE;
            rw_q <= 1'b0;
            addr_q <= eeprom_pkg::ADDR_RST;
            wbase_q <= eeprom_pkg::ADDR_RST;
            wptr_q <= 5'h00;
            page_v_q <= 32'h0;
            wdata_q <= 1'b0;
            prog_cnt_q <= 32'h0;
            busy_q <= 1'b0;
        end else if (st_q == eeprom_pkg::ST_PROG) begin
            // bus ignored entirely while the cell array is busy
            if (prog_cnt_q == 32'(WRITE_CYCLES - 1)) begin
                st_q <= eeprom_pkg::ST_IDLE;
                busy_q <= 1'b0;
                page_v_q <= 32'h0;
            end else begin
                prog_cnt_q <= prog_cnt_q + 32'h1;
            end
        end else if (start_c) begin
            st_q <= eeprom_pkg::ST_DEV;
            page_v_q <= 32'h0;
            wdata_q <= 1'b0;
        end else if (stop_c) begin
            if (wdata_q && !wp_s_q[1]) begin
                st_q <= eeprom_pkg::ST_PROG;
                busy_q <= 1'b1;
                prog_cnt_q <= 32'h0;
            end else begin
                st_q <= eeprom_pkg::ST_IDLE;
            end
            wdata_q <= 1'b0;
        end else if (scl_rise && bit_q == eeprom_pkg::ACK_BIT) begin
            case (st_q)
                eeprom_pkg::ST_DEV: begin
                    if (ack_ok) begin
                        rw_q <= sh_q[0];
                        st_q <= sh_q[0] ? eeprom_pkg::ST_RDATA
                                        : eeprom_pkg::ST_ADDR_HI;
                    end else begin
                        st_q <= eeprom_pkg::ST_IDLE;
                    end
                end
                eeprom_pkg::ST_ADDR_HI: begin
                    addr_q[11:8] <= sh_q[3:0];
                    st_q <= eeprom_pkg::ST_ADDR_LO;
                end
                eeprom_pkg::ST_ADDR_LO: begin
                    addr_q[7:0] <= sh_q;
                    wbase_q <= {addr_q[11:8], sh_q};
                    wptr_q <= sh_q[4:0];
                    st_q <= eeprom_pkg::ST_WDATA;
                end
                eeprom_pkg::ST_WDATA: begin
                    page_q[wptr_q] <= sh_q;
                    page_v_q[wptr_q] <= 1'b1;
                    wdata_q <= 1'b1;
                    wptr_q <= wptr_q + 5'h01;
                    addr_q <= {wbase_q[11:5], wptr_q + 5'h01};
                end
                eeprom_pkg::ST_RDATA: begin
                    // byte finished: counter advances, wraps across array
                    addr_q <= addr_q + 12'h001;
                    st_q <= sda_q ? eeprom_pkg::ST_IDLE
                                  : eeprom_pkg::ST_RDATA;
                end
                default: st_q <= st_q;
            endcase
        end
    end

    // commit of buffered page into the array at end of timed cycle
    always_ff @(posedge clk) begin
        if (!rst && st_q == eeprom_pkg::ST_PROG
            && prog_cnt_q == 32'(WRITE_CYCLES - 1)) begin
            for (int i = 0; i < 32; i++) begin
                if (page_v_q[i]) begin
                    mem[{wbase_q[11:5], 5'(i)}] <= page_q[i];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // sda driver, updated on scl fall, released at once on start or stop
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst || stop_c || start_c) begin
            sda_oe <= 1'b0;
            acking_q <= 1'b0;
        end else if (scl_fall) begin
            acking_q <= 1'b0;
            sda_oe <= 1'b0;
            if (bit_q == 4'h7 && st_q != eeprom_pkg::ST_IDLE
                && st_q != eeprom_pkg::ST_PROG && st_q != eeprom_pkg::ST_RDATA) begin
                // device byte acks only on match; busy means idle-like prog
                if (st_q != eeprom_pkg::ST_DEV || ack_ok) begin
                    sda_oe <= 1'b1;
                    acking_q <= 1'b1;
                end
            end else if (st_q == eeprom_pkg::ST_RDATA && bit_q != 4'h7
                         && bit_q != eeprom_pkg::ACK_BIT) begin
                // fall ending bit n puts out bit n+1, msb first
                sda_oe <= ~rd_byte[3'(4'h6 - bit_q)];
            end else if (st_q == eeprom_pkg::ST_RDATA
                         && bit_q == eeprom_pkg::ACK_BIT) begin
                sda_oe <= ~rd_byte[7];
            end else if (st_q == eeprom_pkg::ST_RDATA && bit_q == 4'h7) begin
                sda_oe <= 1'b0; // release for controller ack
            end
        end
    end
    assign sda_o = 1'b0;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    prog_ignores_bus_a: assert property (@(posedge clk) disable iff (rst)
        (st_q == eeprom_pkg::ST_PROG) |-> !sda_oe)
        else $error("sda driven during programming");
    wp_blocks_prog_a: assert property (@(posedge clk) disable iff (rst)
        (stop_c && wp_s_q[1] && st_q != eeprom_pkg::ST_PROG)
        |=> st_q == eeprom_pkg::ST_IDLE)
        else $error("programming started while protected");
    stop_idle_a: assert property (@(posedge clk) disable iff (rst)
        (stop_c && !wdata_q && st_q != eeprom_pkg::ST_PROG)
        |=> st_q == eeprom_pkg::ST_IDLE)
        else $error("read stop did not reach standby");
    start_dev_a: assert property (@(posedge clk) disable iff (rst)
        (start_c && st_q != eeprom_pkg::ST_PROG) |=> st_q == eeprom_pkg::ST_DEV)
        else $error("start not taken");
    busy_prog_a: assert property (@(posedge clk) disable iff (rst)
        busy_q == (st_q == eeprom_pkg::ST_PROG))
        else $error("busy flag disagrees with state");
    read_wrap_a: assert property (@(posedge clk) disable iff (rst)
        (scl_rise && bit_q == eeprom_pkg::ACK_BIT && st_q == eeprom_pkg::ST_RDATA
         && !start_c && !stop_c && addr_q == 12'hFFF) |=> addr_q == 12'h000)
        else $error("read address did not wrap");
    page_wrap_a: assert property (@(posedge clk) disable iff (rst)
        (st_q == eeprom_pkg::ST_WDATA) |-> addr_q[11:5] == wbase_q[11:5])
        else $error("page write left its page");
    ack_window_a: assert property (@(posedge clk) disable iff (rst)
        $rose(acking_q) |-> bit_q == eeprom_pkg::ACK_BIT)
        else $error("ack outside ninth clock");
    // a slipped bit count would shift every byte by one position
    first_fall_a: assert property (@(posedge clk) disable iff (rst)
        (after_start_q && scl_fall) |=> bit_q == 4'h0)
        else $error("start clock counted as data");
    no_ack_foreign_a: assert property (@(posedge clk) disable iff (rst)
        (scl_fall && bit_q == 4'h7 && st_q == eeprom_pkg::ST_DEV && !ack_ok) |=> !sda_oe)
        else $error("acknowledged a foreign address");
    dir_select_a: assert property (@(posedge clk) disable iff (rst)
        (scl_rise && bit_q == eeprom_pkg::ACK_BIT && st_q == eeprom_pkg::ST_DEV && ack_ok
         && !start_c && !stop_c)
        |=> st_q == ($past(sh_q[0]) ? eeprom_pkg::ST_RDATA : eeprom_pkg::ST_ADDR_HI)
            && rw_q == $past(sh_q[0]))
        else $error("direction bit misread");
    ack_release_a: assert property (@(posedge clk) disable iff (rst)
        (scl_fall && bit_q == eeprom_pkg::ACK_BIT && acking_q && !start_c && !stop_c
         && st_q != eeprom_pkg::ST_RDATA) |=> !sda_oe)
        else $error("ack held past ninth clock");
    data_ack_a: assert property (@(posedge clk) disable iff (rst)
        (scl_fall && bit_q == 4'h7 && st_q == eeprom_pkg::ST_WDATA && !start_c && !stop_c)
        |=> sda_oe)
        else $error("data byte not acknowledged");
    read_release_a: assert property (@(posedge clk) disable iff (rst)
        (scl_fall && bit_q == 4'h7 && st_q == eeprom_pkg::ST_RDATA && !start_c && !stop_c)
        |=> !sda_oe)
        else $error("sda held over controller ack");
    prog_length_a: assert property (@(posedge clk) disable iff (rst)
        $fell(busy_q) |-> $past(prog_cnt_q) == 32'(WRITE_CYCLES - 1))
        else $error("write cycle length wrong");
    addr_high_a: assert property (@(posedge clk) disable iff (rst)
        (scl_rise && bit_q == eeprom_pkg::ACK_BIT && st_q == eeprom_pkg::ST_ADDR_HI)
        |=> addr_q[11:8] == $past(sh_q[3:0]))
        else $error("address high nibble not taken");
    restart_drop_a: assert property (@(posedge clk) disable iff (rst)
        (start_c && st_q != eeprom_pkg::ST_PROG) |=> !wdata_q)
        else $error("repeated start kept pending write");
endmodule : eeprom_slave

/* File: pkg/eeprom_pkg.sv */
package eeprom_pkg;
    // ------------------------------------------------------------
    // array geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int PAGE_W = 5;
    localparam int DEPTH = 4096;
    localparam int PAGES = 128;
    localparam logic [3:0] TYPE_CODE = 4'hA;
    localparam logic [11:0] ADDR_RST = 12'h000;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int WRITE_TIME_US = 5000;
    localparam int WRITE_CYCLES = WRITE_TIME_US * CLK_MHZ;
    localparam logic [3:0] ACK_BIT = 4'h8;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_DEV = 3'b001,
        ST_ADDR_HI = 3'b011,
        ST_ADDR_LO = 3'b010,
        ST_WDATA = 3'b110,
        ST_RDATA = 3'b111,
        ST_RACK = 3'b101,
        ST_PROG = 3'b100
    } state_t;
endpackage : eeprom_pkg

/* File: dv/i2c_host_model.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// two-wire bus controller, one bit every 16 clocks
// ------------------------------------------------------------
module i2c_host_model (
    input wire logic clk, // system clock
    output logic scl = 1'b1, // bus clock, stands high between frames
    output logic sda_low = 1'b0, // pull data line low
    input wire logic sda_in, // resolved data line
    output logic got = 1'b0, // one-cycle result strobe
    output logic got_kind = 1'b0, // 1 read byte, 0 ack bit
    output logic [7:0] got_val = 8'h00 // result value
);
    task automatic q(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : q
    // data moves only in the low phase
    task automatic bit_io(input logic b, output logic r);
        sda_low = !b;
        q(4);
        scl = 1'b1;
        q(4);
        r = sda_in;
        q(4);
        scl = 1'b0;
        q(4);
    endtask : bit_io
    task automatic bus_start();
        sda_low = 1'b0;
        q(4);
        scl = 1'b1;
        q(4);
        sda_low = 1'b1;
        q(4);
        scl = 1'b0;
        q(4);
    endtask : bus_start
    task automatic bus_stop();
        sda_low = 1'b1;
        q(4);
        scl = 1'b1;
        q(4);
        sda_low = 1'b0;
        q(4);
    endtask : bus_stop
    // mack low asks for another byte, high ends the read
    task automatic xfer(input logic rd, input logic [7:0] d, input logic mack);
        logic [7:0] r;
        logic a;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
        bit_io(mack, a);
        got_kind = rd;
        got_val = rd ? r : {7'h00, a};
        got = 1'b1;
        q(1);
        got = 1'b0;
    endtask : xfer
endmodule : i2c_host_model

/* File: dv/eeprom_slave_test.sv */
`timescale 1ns/1ps
module eeprom_slave_test;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wp_i = 1'b0;
    logic [2:0] chip_select_pins = 3'h0;
    logic scl, sda_low, sda_o, sda_oe, busy_q, got, got_kind;
    logic [7:0] got_val;
    // open drain with pull-up
    wire sda = !(sda_low || (sda_oe && !sda_o));
    int n_mismatch = 0;
    int compares = 0;
    logic [8:0] notes[$];
    logic [7:0] mem[int];
    logic [2:0] cs;
    logic [11:0] a;
    eeprom_slave #(.WRITE_CYCLES(200)) i_eeprom_slave (.clk(clk), .rst(rst), .scl_i(scl),
        .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .chip_select_pins(chip_select_pins),
        .wp_i(wp_i), .busy_q(busy_q));
    i2c_host_model i_i2c_host_model (.clk(clk), .scl(scl), .sda_low(sda_low), .sda_in(sda),
        .got(got), .got_kind(got_kind), .got_val(got_val));
    initial begin
        forever #5 clk = !clk;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic cmp(input string what, input logic [8:0] exp, input logic [8:0] seen);
        compares++;
        if (exp !== seen) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : cmp
    task automatic summarize();
        tick(4);
        if (notes.size() != 0) begin
            n_mismatch++;
            $display("BAD notes expected 0 seen %0d", notes.size());
        end
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : summarize
    // ack high means the byte was refused
    task automatic wb(input logic [7:0] d, input logic ack);
        notes.push_back({1'b0, 7'h00, ack});
        i_i2c_host_model.xfer(1'b0, d, 1'b1);
    endtask : wb
    task automatic rb(input logic [7:0] e, input logic last);
        notes.push_back({1'b1, e});
        i_i2c_host_model.xfer(1'b1, 8'hFF, last);
    endtask : rb
    task automatic dev(input logic rd, input logic ack);
        i_i2c_host_model.bus_start();
        wb({4'hA, cs, rd}, ack);
    endtask : dev
    task automatic wait_idle();
        for (int i = 0; i < 400 && busy_q !== 1'b0; i++) tick(1);
        if (busy_q !== 1'b0) begin
            n_mismatch++;
            $display("BAD busy_q expected 0 seen %b", busy_q);
            summarize();
        end
    endtask : wait_idle
    task automatic rd_at(input logic [11:0] ad);
        dev(1'b0, 1'b0);
        wb({4'hF, ad[11:8]}, 1'b0);
        wb(ad[7:0], 1'b0);
        dev(1'b1, 1'b0);
    endtask : rd_at
    task automatic bw(input logic [11:0] ad, input logic [7:0] d);
        dev(1'b0, 1'b0);
        wb({4'h0, ad[11:8]}, 1'b0);
        wb(ad[7:0], 1'b0);
        wb(d, 1'b0);
        i_i2c_host_model.bus_stop();
    endtask : bw
    always @(posedge clk) begin
        if (got === 1'b1) begin
            if (notes.size() == 0) cmp("spare result", 9'h1FF, {got_kind, got_val});
            else cmp("result", notes.pop_front(), {got_kind, got_val});
        end
    end
    initial begin
        void'($urandom(32'h7588));
        cs = 3'($urandom);
        chip_select_pins = cs;
        repeat (16) @(posedge clk);
        #1 rst = 1'b0;
        tick(4);
        i_i2c_host_model.bus_start();
        wb({4'hA, cs ^ 3'h1, 1'b0}, 1'b1);
        i_i2c_host_model.bus_start();
        wb({4'hB, cs, 1'b1}, 1'b1);
        i_i2c_host_model.bus_stop();
        $display("test address filter done");
        a = 12'($urandom);
        mem[a] = 8'($urandom);
        bw(a, mem[a]);
        tick(4);
        cmp("busy_q", 9'h001, {8'h00, busy_q});
        dev(1'b1, 1'b1);
        i_i2c_host_model.bus_stop();
        wait_idle();
        rd_at(a);
        rb(mem[a], 1'b1);
        i_i2c_host_model.bus_stop();
        $display("test byte write and poll done");
        // start near page end so the burst wraps onto itself
        a = {7'($urandom), 5'h00};
        dev(1'b0, 1'b0);
        wb({4'h0, a[11:8]}, 1'b0);
        wb(a[7:0] | 8'h1E, 1'b0);
        for (int i = 0; i < 33; i++) begin
            mem[a + 12'((30 + i) % 32)] = 8'($urandom);
            wb(mem[a + 12'((30 + i) % 32)], 1'b0);
        end
        i_i2c_host_model.bus_stop();
        wait_idle();
        rd_at(a);
        for (int i = 0; i < 31; i++) rb(mem[a + 12'(i)], i == 30);
        i_i2c_host_model.bus_stop();
        dev(1'b1, 1'b0);
        rb(mem[a + 12'd31], 1'b1);
        i_i2c_host_model.bus_stop();
        $display("test page write done");
        wp_i = 1'b1;
        bw(a, ~mem[a]);
        tick(8);
        cmp("busy_q", 9'h000, {8'h00, busy_q});
        rd_at(a);
        rb(mem[a], 1'b1);
        i_i2c_host_model.bus_stop();
        wp_i = 1'b0;
        $display("test write protect done");
        mem[12'hFFF] = 8'($urandom);
        mem[12'h000] = 8'($urandom);
        bw(12'hFFF, mem[12'hFFF]);
        wait_idle();
        bw(12'h000, mem[12'h000]);
        wait_idle();
        rd_at(12'hFFF);
        rb(mem[12'hFFF], 1'b0);
        rb(mem[12'h000], 1'b1);
        i_i2c_host_model.bus_stop();
        $display("test read wrap done");
        summarize();
    end
endmodule : eeprom_slave_test
